//--- logic/pmr_rx_status.sv
// Receive-side MII/RMII outputs, status LEDs and strap capture of a
// 10/100 transceiver, with an APB register slave.
// Assumes the line front end supplies a recovered clock with data
// changing on its rising edge; the line, tx_en, irq_out_n_in and strap pins are asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_defines.svh"

module pmr_rx_status (
	input wire logic mclk,
	input wire logic ce,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_clk,
	input wire logic [4:0] line_data,
	input wire logic line_dv,
	input wire logic line_err,
	input wire logic line_crs,
	input wire logic line_col,
	input wire logic line_link,
	input wire logic tx_en,
	input wire logic [2:0] mgmt_addr_strap,
	input wire logic [2:0] op_mode_strap,
	input wire logic iface_select_strap,
	input wire logic irq_pin_func_strap,
	input wire logic regulator_disable_strap,
	input wire logic irq_req,
	input wire logic irq_out_n_in,
	output logic irq_out_n_out,
	output logic irq_out_n_oe,
	output logic tx_symbol_msb,
	output logic rx_clk,
	output logic [3:0] rxd,
	output logic rx_dv,
	output logic rx_symbol_msb,
	output logic crs,
	output logic col_crs_dv,
	output logic [2:0] mgmt_addr,
	output logic [2:0] op_mode,
	output logic rmii_mode,
	output logic regulator_en,
	output logic link_activity_led,
	output logic link_speed_led
);

	localparam logic [9:0] BLINK = 10'(`PMR_BLINK_CYC);

	logic [1:0] rst_pipe;
	logic rst_s_n;
	pmr_pkg::pmr_line_t line_raw;
	pmr_pkg::pmr_line_t ln;
	pmr_pkg::pmr_strap_t strap_raw;
	pmr_pkg::pmr_strap_t sp;

	// Reset released through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_s_n = rst_pipe[1];

	// Pin inputs gathered for synchronising
	always_comb begin
		line_raw.clk = line_clk;
		line_raw.data = line_data;
		line_raw.dv = line_dv;
		line_raw.err = line_err;
		line_raw.crs = line_crs;
		line_raw.col = line_col;
		line_raw.link = line_link;
		line_raw.tx_en = tx_en;
		line_raw.pin_in = irq_out_n_in;
		strap_raw.addr = mgmt_addr_strap;
		strap_raw.mode = op_mode_strap;
		strap_raw.rmii = iface_select_strap;
		strap_raw.irq_int = irq_pin_func_strap;
		strap_raw.reg_off = regulator_disable_strap;
	end
	pmr_sync #(
		.W($bits(pmr_pkg::pmr_line_t) + $bits(pmr_pkg::pmr_strap_t))
	) u_sync (
		.mclk(mclk),
		.ce(ce),
		.rst_n(rst_s_n),
		.d({line_raw, strap_raw}),
		.q({ln, sp})
	);
	pmr_pkg::pmr_cap_st_t cap_reg, cap_next;
	logic [1:0] capcnt_reg, capcnt_next;
	pmr_pkg::pmr_strap_t strap_reg, strap_next;
	logic cap_load;

	// Wait for the synchroniser to fill, then latch once per reset
	always_comb begin
		cap_next = cap_reg;
		capcnt_next = capcnt_reg;
		strap_next = strap_reg;
		cap_load = 1'b0;
		case (cap_reg)
			pmr_pkg::CAP_WAIT: begin
				if (capcnt_reg == `PMR_STRAP_WAIT) begin
					strap_next = sp;
					cap_load = 1'b1;
					cap_next = pmr_pkg::CAP_DONE;
				end else begin
					capcnt_next = capcnt_reg + 2'h1;
				end
			end
			pmr_pkg::CAP_DONE: begin
				cap_next = pmr_pkg::CAP_DONE;
			end
			default: begin
				cap_next = pmr_pkg::CAP_WAIT;
			end
		endcase
	end
	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cap_reg <= pmr_pkg::CAP_WAIT;
			capcnt_reg <= 2'h0;
			strap_reg <= '0;
		end else if (ce) begin
			cap_reg <= cap_next;
			capcnt_reg <= capcnt_next;
			strap_reg <= strap_next;
		end
	end

	logic done;
	assign done = (cap_reg == pmr_pkg::CAP_DONE);
	logic [`PMR_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;
	logic access, commit, hit;
	logic rmii, spd, fdx, iso, sym;
	logic ferr_reg;
	pmr_pkg::pmr_rx_st_t rx_reg;

	assign rmii = strap_reg.rmii;
	assign spd = ctrl_reg[`PMR_CTRL_SPD];
	assign fdx = ctrl_reg[`PMR_CTRL_FDX];
	assign iso = ctrl_reg[`PMR_CTRL_ISO];
	assign sym = ctrl_reg[`PMR_CTRL_SYM] & ~rmii;
	assign access = psel & penable & ~pready;
	assign commit = psel & penable & pready;

	// Decode, read mux, one wait state, control writes
	always_comb begin
		ctrl_next = ctrl_reg;
		prdata_next = prdata;
		pslverr_next = pslverr;
		pready_next = access;
		hit = (paddr == `PMR_CTRL_OFS) || (paddr == `PMR_STRAP_OFS) ||
			(paddr == `PMR_STAT_OFS);
		if (access) begin
			pslverr_next = ~hit;
			prdata_next = 32'h0;
			if (!pwrite) begin
				case (paddr)
					`PMR_CTRL_OFS: prdata_next = {28'h0, ctrl_reg};
					`PMR_STRAP_OFS: prdata_next = {23'h0, strap_reg};
					`PMR_STAT_OFS: prdata_next = {26'h0, done, ferr_reg,
						(rx_reg == pmr_pkg::RX_PASS), ln.crs, ln.link, rmii};
					default: prdata_next = 32'h0;
				endcase
			end
		end
		if (cap_load) begin
			ctrl_next = '0;
			ctrl_next[`PMR_CTRL_SPD] = sp.mode[`PMR_MODE_SPD];
			ctrl_next[`PMR_CTRL_FDX] = sp.mode[`PMR_MODE_FDX];
		end else if (commit && pwrite && paddr == `PMR_CTRL_OFS) begin
			ctrl_next = pwdata[`PMR_CTRL_W-1:0];
		end
	end
	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ctrl_reg <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			ctrl_reg <= ctrl_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end
	logic lclk_d_reg;
	logic tick;
	pmr_pkg::pmr_rx_st_t rx_next;
	logic [7:0] sh_reg, sh_next;
	logic ferr_next;
	logic echo, pass;
	logic rx_clk_next, rx_dv_next, sym_next, crs_next, ccd_next;
	logic [3:0] rxd_next;

	// Sample line data mid-bit, at the recovered clock's falling edge
	assign tick = lclk_d_reg & ~ln.clk;
	assign echo = rmii & ~spd & ~fdx & ln.tx_en;

	always_comb begin
		rx_next = rx_reg;
		sh_next = sh_reg;
		ferr_next = ferr_reg;
		rxd_next = rxd;
		rx_dv_next = rx_dv;
		sym_next = rx_symbol_msb;
		crs_next = crs;
		ccd_next = col_crs_dv;
		rx_clk_next = ln.clk & ~rmii & done;
		pass = 1'b0;
		if (tick && done) begin
			// Error sticks from detection to frame end
			if (!ln.dv && !ln.crs) begin
				ferr_next = 1'b0;
			end else if (ln.err) begin
				ferr_next = 1'b1;
			end
			case (rx_reg)
				pmr_pkg::RX_IDLE: begin
					sh_next = 8'h00;
					if (ln.crs) begin
						rx_next = (rmii && !spd) ? pmr_pkg::RX_HUNT : pmr_pkg::RX_PASS;
					end
				end
				pmr_pkg::RX_HUNT: begin
					sh_next = {sh_reg[5:0], ln.data[0], ln.data[1]};
					if (sh_next == `PMR_SFD) begin
						rx_next = pmr_pkg::RX_PASS;
					end
				end
				pmr_pkg::RX_PASS: begin
					pass = ln.dv;
				end
				default: begin
					rx_next = pmr_pkg::RX_IDLE;
				end
			endcase
			if (!ln.crs) begin
				rx_next = pmr_pkg::RX_IDLE;
			end
			if (iso) begin
				rxd_next = 4'h0;
				rx_dv_next = 1'b0;
				sym_next = 1'b0;
				crs_next = 1'b0;
				ccd_next = 1'b0;
			end else if (!rmii) begin
				rxd_next = ln.dv ? ln.data[3:0] : 4'h0;
				rx_dv_next = ln.dv;
				sym_next = sym ? (ln.dv & ln.data[4]) : ferr_next;
				crs_next = ln.crs;
				ccd_next = ln.col;
			end else begin
				rxd_next = {2'h0, (pass && !echo) ? ln.data[1:0] : 2'h0};
				rx_dv_next = 1'b0;
				sym_next = ferr_next;
				crs_next = 1'b0;
				ccd_next = ln.crs;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			lclk_d_reg <= 1'b0;
			rx_reg <= pmr_pkg::RX_IDLE;
			sh_reg <= 8'h00;
			ferr_reg <= 1'b0;
			rx_clk <= 1'b0;
			rxd <= 4'h0;
			rx_dv <= 1'b0;
			rx_symbol_msb <= 1'b0;
			crs <= 1'b0;
			col_crs_dv <= 1'b0;
		end else if (ce) begin
			lclk_d_reg <= ln.clk;
			rx_reg <= rx_next;
			sh_reg <= sh_next;
			ferr_reg <= ferr_next;
			rx_clk <= rx_clk_next;
			rxd <= rxd_next;
			rx_dv <= rx_dv_next;
			rx_symbol_msb <= sym_next;
			crs <= crs_next;
			col_crs_dv <= ccd_next;
		end
	end
	logic [10:0] blink_reg, blink_next;
	logic act_led_next, spd_led_next;
	logic irq_oe_next, txs_next;

	// Blink: off for one period then on for one, started by traffic only once the previous blink has ended
	always_comb begin
		blink_next = blink_reg;
		if (blink_reg != 11'h000) begin
			blink_next = blink_reg - 11'h001;
		end else if (tick && (ln.dv || ln.tx_en)) begin
			blink_next = {BLINK, 1'b0};
		end
		act_led_next = ln.link & done & (blink_reg <= {1'b0, BLINK});
		spd_led_next = spd & ~iso & done;
		irq_oe_next = done & strap_reg.irq_int & irq_req;
		txs_next = done & ~strap_reg.irq_int & ln.pin_in;
	end

	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			blink_reg <= 11'h000;
			link_activity_led <= 1'b0;
			link_speed_led <= 1'b0;
			irq_out_n_out <= 1'b0;
			irq_out_n_oe <= 1'b0;
			tx_symbol_msb <= 1'b0;
			mgmt_addr <= 3'h0;
			op_mode <= 3'h0;
			rmii_mode <= 1'b0;
			regulator_en <= 1'b1;
		end else if (ce) begin
			blink_reg <= blink_next;
			link_activity_led <= act_led_next;
			link_speed_led <= spd_led_next;
			irq_out_n_out <= 1'b0; // Open drain: pulls low only
			irq_out_n_oe <= irq_oe_next;
			tx_symbol_msb <= txs_next;
			mgmt_addr <= strap_next.addr;
			op_mode <= strap_next.mode;
			rmii_mode <= strap_next.rmii;
			regulator_en <= ~(done & strap_reg.reg_off);
		end
	end

endmodule

`default_nettype wire

//--- logic/pmr_defines.svh
// Constants of the receive/status block: offsets, field positions,
// the delimiter, clock rates and timing counts.
// Assumes the includer adds nothing of its own under these names.
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// APB register offsets (byte addresses)
`define PMR_CTRL_OFS 12'h000
`define PMR_STRAP_OFS 12'h004
`define PMR_STAT_OFS 12'h008

// Control register field positions
`define PMR_CTRL_SPD 0
`define PMR_CTRL_FDX 1
`define PMR_CTRL_ISO 2
`define PMR_CTRL_SYM 3
`define PMR_CTRL_W 4

// Operating mode strap bit positions
`define PMR_MODE_SPD 0
`define PMR_MODE_FDX 1

// Start-of-frame delimiter in line order, first bit in the MSB
`define PMR_SFD 8'hAB

// Receive clock rates in kHz, for reference only; neither the design nor the bench uses them
`define PMR_RXCLK_100_KHZ 25000
`define PMR_RXCLK_10_KHZ 2500

// Timing
`define PMR_MCLK_KHZ 10000
`define PMR_BLINK_NS 50000
`define PMR_BLINK_CYC ((`PMR_BLINK_NS * `PMR_MCLK_KHZ) / 1000000)
`define PMR_STRAP_WAIT 2'h3

`endif

//--- logic/pmr_pkg.sv
// Types shared by the receive/status block.
// Assumes pmr_defines.svh carries the numeric constants.
package pmr_pkg;

	// Line-side and MAC-side inputs crossing into mclk
	typedef struct packed {
		logic clk;
		logic [4:0] data;
		logic dv;
		logic err;
		logic crs;
		logic col;
		logic link;
		logic tx_en;
		logic pin_in;
	} pmr_line_t;

	// Configuration straps
	typedef struct packed {
		logic [2:0] addr;
		logic [2:0] mode;
		logic rmii;
		logic irq_int;
		logic reg_off;
	} pmr_strap_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_HUNT = 3'h2,
		RX_PASS = 3'h4
	} pmr_rx_st_t;

	typedef enum logic [1:0] {
		CAP_WAIT = 2'h1,
		CAP_DONE = 2'h2
	} pmr_cap_st_t;

endpackage

//--- logic/pmr_sync.sv
// Two-flop synchroniser bank for inputs from outside the mclk domain.
// Assumes a synchronous-release reset and a clock enable on mclk.
`timescale 1ns/1ns
`default_nettype none

module pmr_sync #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic ce,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule

`default_nettype wire

//--- test/pmr_rx_status_assertions.sv
// Checker on the ports of the receive/status block.
// Assumes ce is held high and one mclk domain.
`timescale 1ns/1ns
`default_nettype none

module pmr_rx_status_assertions (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic line_clk,
	input wire logic irq_req,
	input wire logic irq_out_n_out,
	input wire logic irq_out_n_oe,
	input wire logic rx_clk,
	input wire logic [3:0] rxd,
	input wire logic rx_dv,
	input wire logic crs,
	input wire logic [2:0] mgmt_addr,
	input wire logic [2:0] op_mode,
	input wire logic rmii_mode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// APB access phase still waiting
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_pulse;
		pready ##1 !pready;
	endsequence
	property p_ans;
		s_acc |=> s_pulse;
	endproperty
	a_ans: assert property (p_ans) else $error("APB answer wrong");
	property p_rmii;
		rmii_mode |-> !rx_clk && !rx_dv && !crs && rxd[3:2] == 2'h0;
	endproperty
	a_rmii: assert property (p_rmii) else $error("RMII pins wrong");
	property p_idle;
		!rmii_mode && !rx_dv |-> rxd == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("Data without valid");
	property p_rise;
		$rose(rx_clk) |-> $past(line_clk, 3) || $past(line_clk, 4);
	endproperty
	a_rise: assert property (p_rise) else $error("Rx clock rise");
	property p_fall;
		$fell(rx_clk) |-> !$past(line_clk, 3) || !$past(line_clk, 4);
	endproperty
	a_fall: assert property (p_fall) else $error("Rx clock fall");
	property p_keep;
		mgmt_addr != 3'h0 |=> $stable({mgmt_addr, op_mode, rmii_mode});
	endproperty
	a_keep: assert property (p_keep) else $error("Strap result moved");
	property p_od;
		irq_out_n_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("Pin driven high");
	property p_oe;
		!irq_req |=> !irq_out_n_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("Pin pulled unasked");
endmodule

bind pmr_rx_status pmr_rx_status_assertions u_chk (
	.mclk(mclk),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.line_clk(line_clk),
	.irq_req(irq_req),
	.irq_out_n_out(irq_out_n_out),
	.irq_out_n_oe(irq_out_n_oe),
	.rx_clk(rx_clk),
	.rxd(rxd),
	.rx_dv(rx_dv),
	.crs(crs),
	.mgmt_addr(mgmt_addr),
	.op_mode(op_mode),
	.rmii_mode(rmii_mode)
);
`default_nettype wire

//--- test/pmr_line_model.sv
// Line front end and MAC side: line clock, code groups, status.
// Assumes the caller spaces frames; the clock stands still between them.
`timescale 1ns/1ns
`default_nettype none

module pmr_line_model (
	output logic line_clk,
	output logic [4:0] line_data,
	output logic [3:0] line_flags,
	input wire logic [7:0] obs
);
	logic [7:0] seen;
	// Idle levels
	initial begin
		line_clk = 1'b0;
		line_data = 5'h00;
		line_flags = 4'h0;
	end
	// One 800 ns cycle; outputs taken 200 ns after the rise
	task automatic cyc(input logic [3:0] f, input logic [4:0] d);
		line_clk = 1'b1;
		line_data = d;
		line_flags = f;
		#200 seen = obs;
		#200 line_clk = 1'b0;
		#400;
	endtask
	// Data no longer holds once the frame is over
	task automatic stop();
		line_data = ~line_data;
		line_flags = 4'h0;
	endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
// Bench: straps, APB registers, RMII and MII receive frames.
// Assumes design files and the line model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_defines.svh"

module tb_top;
	logic mclk = 1'b0;
	logic ce = 1'b1;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic tx_en = 1'b0;
	logic line_link = 1'b0;
	logic irq_req = 1'b0;
	logic irq_out_n_in = 1'b0;
	pmr_pkg::pmr_strap_t st = '0;
	wire logic [2:0] mgmt_addr_strap = st.addr;
	wire logic [2:0] op_mode_strap = st.mode;
	wire logic iface_select_strap = st.rmii;
	wire logic irq_pin_func_strap = st.irq_int;
	wire logic regulator_disable_strap = st.reg_off;
	wire logic line_clk, line_dv, line_err, line_crs, line_col;
	wire logic [4:0] line_data;
	logic [31:0] prdata, r;
	logic pready, pslverr, irq_out_n_out, irq_out_n_oe, tx_symbol_msb, rx_clk, e;
	logic [3:0] rxd;
	logic rx_dv, rx_symbol_msb, crs, col_crs_dv, rmii_mode, regulator_en;
	logic [2:0] mgmt_addr, op_mode;
	logic link_activity_led, link_speed_led;
	int mismatches = 0;
	int n_tests = 0;
	int cyc_n = 0;
	int rcnt = 0;
	pmr_rx_status dut (.*);
	pmr_line_model lm (
		.line_clk(line_clk),
		.line_data(line_data),
		.line_flags({line_crs, line_dv, line_col, line_err}),
		.obs({rx_dv, crs, col_crs_dv, rx_symbol_msb, rxd})
	);
	// Clock
	initial begin
		forever #50 mclk = ~mclk;
	end
	// Hang limit
	always @(posedge mclk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	// Receive clock rises
	always @(posedge rx_clk) begin
		rcnt++;
	end
	task automatic end_sim();
		$display("Tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// One APB transfer, held until pready; only the hang limit ends a wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	// Reset with given straps, then poll for capture
	task automatic rst_cap(input pmr_pkg::pmr_strap_t s, input logic [31:0] x);
		int n = 0;
		st <= s;
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		do begin
			apb(1'b0, `PMR_STAT_OFS, 32'h0);
			n++;
		end while (r[5] !== 1'b1 && n < 20);
		chk(r, x);
		rd(`PMR_STRAP_OFS, 32'(s));
	endtask
	// One line cycle; FF skips the compare
	task automatic ln(input logic [3:0] f, input logic [4:0] d, input logic [7:0] x);
		lm.cyc(f, d);
		if (x !== 8'hFF) chk(32'(lm.seen), 32'(x));
	endtask
	// RMII 10M frame: preamble, delimiter, three dibits
	task automatic rmii_fr(input logic m);
		logic [7:0] k;
		k = m ? 8'h20 : 8'h2F;
		#37;
		ln(4'hC, 5'h01, 8'h00);
		repeat (10) ln(4'hC, 5'h01, 8'h20);
		ln(4'hC, 5'h03, 8'h20);
		ln(4'hC, 5'h02, 8'h20);
		ln(4'hC, 5'h03, 8'h22 & k);
		ln(4'hC, 5'h01, 8'h23 & k);
		ln(4'h0, 5'h00, 8'h21 & k);
		ln(4'h0, 5'h00, 8'h00);
		lm.stop();
		@(posedge mclk);
	endtask
	initial begin
		rst_cap(9'h165, 32'h21);
		chk(32'({mgmt_addr, op_mode, rmii_mode, regulator_en}), 32'hB2);
		st <= 9'h0AA;
		repeat (10) @(posedge mclk);
		chk(32'({mgmt_addr, op_mode, rmii_mode, regulator_en}), 32'hB2);
		rd(12'h00C, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'b1, `PMR_STRAP_OFS, 32'h0);
		rd(`PMR_STRAP_OFS, 32'h165);
		apb(1'b1, `PMR_CTRL_OFS, 32'h6);
		rd(`PMR_CTRL_OFS, 32'h6);
		apb(1'b1, `PMR_CTRL_OFS, 32'h0);
		irq_req <= 1'b1;
		irq_out_n_in <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(32'({tx_symbol_msb, irq_out_n_oe}), 32'h2);
		irq_req <= 1'b0;
		$display("test straps and regs done");
		rmii_fr(1'b0);
		tx_en <= 1'b1;
		rmii_fr(1'b1);
		tx_en <= 1'b0;
		line_link <= 1'b1;
		$display("test rmii done");
		rst_cap(9'h08A, 32'h22);
		chk(32'({mgmt_addr, op_mode, rmii_mode, regulator_en, link_speed_led}), 32'h8B);
		chk(32'(link_activity_led), 32'h1);
		apb(1'b1, `PMR_CTRL_OFS, 32'h5);
		repeat (2) @(posedge mclk);
		chk(32'(link_speed_led), 32'h0);
		apb(1'b1, `PMR_CTRL_OFS, 32'h1);
		irq_req <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(32'({tx_symbol_msb, irq_out_n_oe}), 32'h1);
		irq_req <= 1'b0;
		rcnt = 0;
		#37;
		ln(4'hE, 5'h0A, 8'h00);
		ln(4'hF, 5'h13, 8'hEA);
		ln(4'hE, 5'h05, 8'hFF);
		ln(4'h0, 5'h00, 8'hF5);
		ln(4'h0, 5'h00, 8'h00);
		lm.stop();
		chk(32'(rcnt), 32'h5);
		chk(32'(link_activity_led), 32'h0);
		@(posedge mclk);
		apb(1'b1, `PMR_CTRL_OFS, 32'h9);
		#37;
		ln(4'hC, 5'h1C, 8'h00);
		ln(4'h0, 5'h00, 8'hDC);
		ln(4'h0, 5'h00, 8'h00);
		lm.stop();
		$display("test mii done");
		repeat (1200) @(posedge mclk);
		chk(32'(link_activity_led), 32'h1);
		end_sim();
	end
endmodule

`default_nettype wire
